// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dstu_pkg::*;
    // ****************************************
    // Clock, reset and design hookup
    // ****************************************
    localparam int unsigned STEP_T = 20;
    localparam int unsigned LST_T  = 200;
    logic        sys_clk;
    logic        reset;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    dstu_cfg_t   cfg;
    logic        osc_peer_clk;
    logic        peer_wd_fault;
    dstu_stim_t  stim;
    logic [11:0] angle_meas;
    logic        angle_valid;
    logic        osc_run;
    logic        bad_angle;
    logic [7:0]  seen_elems;
    logic        seen_cfg;
    logic [31:0] rd;
    int          err_total;
    int          checks_done;
    int          cyc;
    int          n;

    dstu_top #(.LST_CYCLES(LST_T), .STEP_CYCLES(STEP_T)) DUT (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq             (irq),
        .cfg             (cfg),
        .osc_peer_clk    (osc_peer_clk),
        .peer_wd_fault   (peer_wd_fault),
        .stim            (stim),
        .angle_meas      (angle_meas),
        .angle_valid     (angle_valid)
    );

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // Peer oscillator at half rate; stopping it emulates a dead oscillator
    always @(posedge sys_clk) begin
        if (osc_run) begin
            osc_peer_clk <= ~osc_peer_clk;
        end
    end

    // ****************************************
    // Transducer front end stand-in
    // ****************************************
    // Angle follows the driven element; offset stays inside the tolerance unless bad_angle is set
    always @(posedge sys_clk) begin
        angle_valid <= stim.test_cfg && (($urandom % 3) == 0);
        angle_meas  <= {stim.elem, 9'h000} + (bad_angle ? 12'h400 :
                       12'($urandom % 16));
        if (stim.test_cfg) begin
            seen_elems[stim.elem] <= 1'b1;
            seen_cfg <= 1'b1;
        end
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            err_total++;
            wrap_up();
        end
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request stands until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 100);
        q = avs_readdata;
        if (k >= 100) begin
            err_total++;
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
        bus_xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(16));
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        cfg = '{dst: 1'b0, lbe: 1'b1, cse: 1'b1};
        osc_peer_clk = 1'b0;
        peer_wd_fault = 1'b0;
        osc_run = 1'b1;
        bad_angle = 1'b0;
        seen_elems = 8'h00;
        seen_cfg = 1'b0;
        wait_cyc(10);
        reset <= 1'b0;
        // Power-up starts both tests together
        wait_cyc(3);
        bus_rd(OFS_STATUS, rd);
        chk("pwrup_status", rd[3:0] & 4'h7, 4'h6);
        wait_cyc(400);
        bus_rd(OFS_STATUS, rd);
        chk("done_status", rd[3:0], 4'h9);
        chk("elems_swept", seen_elems, 8'hFF);
        chk("test_cfg_used", seen_cfg, 1'b1);
        chk("test_cfg_off", stim.test_cfg, 1'b0);
        bus_rd(OFS_SIG, rd);
        n = (rd[30:0] !== 31'h0000_0000);
        bus_rd(OFS_STATUS, rd);
        chk("lst_verdict", rd[4], n[0]);
        bus_rd(OFS_ISTAT, rd);
        chk("istat_both", rd[3:0], 4'h3);
        bus_rd(OFS_ISTAT, rd);
        chk("istat_clear", rd[3:0], 4'h0);
        bus_rd(OFS_IMASK, rd);
        chk("imask_rst", rd[3:0], IMASK_RST);
        // Command start refused while the disable bit is set
        cfg <= '{dst: 1'b1, lbe: 1'b1, cse: 1'b1};
        bus_wr(OFS_CTRL, {24'h000000, CMD_XST});
        wait_cyc(5);
        bus_rd(OFS_STATUS, rd);
        chk("dst_blocks", rd[1], 1'b0);
        cfg <= '{dst: 1'b0, lbe: 1'b1, cse: 1'b1};
        // Failing run by command, timed through the interrupt
        bad_angle <= 1'b1;
        bus_wr(OFS_ERR, 32'h0000_0001);
        bus_wr(OFS_IMASK, 32'h0000_0001);
        bus_wr(OFS_CTRL, {24'h000000, CMD_XST});
        bus_rd(OFS_STATUS, rd);
        chk("cmd_running", rd[1:0], 2'h2);
        n = 4;
        while (irq !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        chk("xst_time_ok", (n >= 8 * STEP_T) && (n <= 8 * STEP_T + 8),
            1'b1);
        bus_rd(OFS_ERR, rd);
        chk("fail_flag", rd[0], 1'b1);
        bus_rd(OFS_ISTAT, rd);
        chk("istat_fail", rd[3:0], 4'h5);
        wait_cyc(1);
        chk("irq_cleared", irq, 1'b0);
        bus_wr(OFS_ERR, 32'h0000_0001);
        bus_rd(OFS_ERR, rd);
        chk("fail_w1c", rd[0], 1'b0);
        bad_angle <= 1'b0;
        // Passing transducer run with a logic test started beside it;
        // only the failure event is unmasked, so irq must stay low
        bus_wr(OFS_IMASK, 32'h0000_0004);
        bus_wr(OFS_CTRL, {24'h000000, CMD_XST});
        bus_wr(OFS_CTRL, {24'h000000, CMD_LST});
        bus_rd(OFS_STATUS, rd);
        chk("lst_running", rd[2:1], 2'h3);
        wait_cyc(LST_T + 20);
        chk("masked_irq", irq, 1'b0);
        bus_rd(OFS_ISTAT, rd);
        chk("lst_event", rd[3:0], 4'h3);
        bus_rd(OFS_ERR, rd);
        chk("pass_no_fail", rd[0], 1'b0);
        bus_rd(OFS_STATUS, rd);
        chk("pass_done", rd[3:0], 4'h9);
        bus_rd(8'h1C, rd);
        chk("unmapped", rd, 32'h0000_0000);
        // Watchdog sees half rate in range, then a stopped oscillator
        bus_rd(OFS_WDCNT, rd);
        chk("wd_count_ok", (rd >= 100) && (rd <= 156), 1'b1);
        bus_rd(OFS_ERR, rd);
        chk("wd_clean", rd[2], 1'b0);
        osc_run <= 1'b0;
        wait_cyc(700);
        bus_rd(OFS_ERR, rd);
        chk("wd_fault", rd[2], 1'b1);
        bus_rd(OFS_ISTAT, rd);
        chk("wd_event", rd[3], 1'b1);
        // Reset in mid-run clears the fault; the peer's fault then sets it
        reset   <= 1'b1;
        osc_run <= 1'b1;
        wait_cyc(3);
        reset <= 1'b0;
        wait_cyc(2);
        bus_rd(OFS_ERR, rd);
        chk("wd_after_rst", rd[2], 1'b0);
        peer_wd_fault <= 1'b1;
        wait_cyc(5);
        bus_rd(OFS_ERR, rd);
        chk("peer_fault", rd[2], 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== verilog/dstu_pkg.sv
`default_nettype none
package dstu_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned LST_TIME_MS  = 30;
    localparam int unsigned XST_TIME_MS  = 30;
    localparam int unsigned XST_STEPS    = 8;
    localparam int unsigned LST_CYC      = LST_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned XST_STEP_CYC =
        XST_TIME_MS * 1000 * CLK_MHZ / XST_STEPS;
    localparam int unsigned WD_WIN_CYC   = 256;
    // ****************************************
    // Structure
    // ****************************************
    localparam int unsigned NUM_CHAINS = 31;
    localparam int unsigned SIG_W      = 31;
    localparam logic [30:0] LFSR_SEED  = 31'h0000_0001;
    localparam logic [30:0] MISR_INIT  = 31'h0000_0000;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ERR    = 8'h08;
    localparam logic [7:0] OFS_ISTAT  = 8'h0C;
    localparam logic [7:0] OFS_IMASK  = 8'h10;
    localparam logic [7:0] OFS_SIG    = 8'h14;
    localparam logic [7:0] OFS_WDCNT  = 8'h18;
    localparam logic [7:0] CMD_XST    = 8'h5A;
    localparam logic [7:0] CMD_LST    = 8'hA5;
    localparam logic [3:0] IMASK_RST  = 4'h0;
    // Event bits: 0 xst done, 1 lst done, 2 xst fail, 3 watchdog fault
    localparam int unsigned EV_XDN = 0;
    localparam int unsigned EV_LDN = 1;
    localparam int unsigned EV_XF  = 2;
    localparam int unsigned EV_WD  = 3;

    typedef struct packed {
        logic dst;
        logic lbe;
        logic cse;
    } dstu_cfg_t;

    typedef struct packed {
        logic       test_cfg;
        logic       cur_dir;
        logic [2:0] elem;
    } dstu_stim_t;

    typedef enum logic [2:0] {
        XS_IDLE = 3'b001,
        XS_RUN  = 3'b010,
        XS_DONE = 3'b100
    } dstu_xst_t;
endpackage
`default_nettype wire

// ===== verilog/dstu_top.sv
`default_nettype none
module dstu_top
    import dstu_pkg::*;
#(
    parameter int unsigned LST_CYCLES = LST_CYC,
    parameter int unsigned STEP_CYCLES = XST_STEP_CYC,
    parameter int unsigned CHAIN_LEN  = 8,
    parameter int unsigned WD_LO      = 100,
    parameter int unsigned WD_HI      = 156,
    parameter logic [30:0] EXP_SIG    = 31'h0000_0000,
    parameter logic [11:0] ANGLE_TOL  = 12'h020
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // Stored configuration (same clock)
    input  wire dstu_cfg_t   cfg,
    // Oscillator watchdog
    input  wire logic        osc_peer_clk,
    input  wire logic        peer_wd_fault,
    // Transducer front end
    output dstu_stim_t       stim,
    input  wire logic [11:0] angle_meas,
    input  wire logic        angle_valid
);
    // ****************************************
    // Register bus
    // ****************************************
    logic        ack_q;
    logic        wr_en;
    logic        rd_done;
    logic [31:0] rd_d;
    logic [3:0]  istat_q;
    logic [3:0]  imask_q;
    logic [3:0]  ev;
    logic        sdn_q;
    logic        stf_q;
    logic        lfail_q;
    logic        ldone_q;
    logic        lrun_q;
    logic        wd_fault_q;
    logic [30:0] misr_q;
    logic [15:0] wd_last_q;
    dstu_xst_t   xs_q;

    assign avs_waitrequest = ~ack_q;
    assign wr_en   = avs_write & ack_q;
    assign rd_done = avs_read & ack_q;
    assign irq     = |(istat_q & imask_q);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (avs_address)
            OFS_STATUS: rd_d = {27'h0, lfail_q, ldone_q, lrun_q,
                                xs_q == XS_RUN, sdn_q};
            OFS_ERR:    rd_d = {29'h0, wd_fault_q, lfail_q, stf_q};
            // Same-cycle events join the word, as the read clears them
            OFS_ISTAT:  rd_d = {28'h0, istat_q | ev};
            OFS_IMASK:  rd_d = {28'h0, imask_q};
            OFS_SIG:    rd_d = {1'b0, misr_q};
            OFS_WDCNT:  rd_d = {16'h0, wd_last_q};
            default:    rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            avs_readdata <= rd_d;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            imask_q <= IMASK_RST;
        end else if (wr_en && avs_address == OFS_IMASK) begin
            imask_q <= avs_writedata[3:0];
        end
    end

    // Set wins over read-clear so no event is lost
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            istat_q <= 4'h0;
        end else if (rd_done && avs_address == OFS_ISTAT) begin
            istat_q <= ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end

    // ****************************************
    // Start requests
    // ****************************************
    logic pwr_q;
    logic cmd_xst;
    logic cmd_lst;
    logic start_x;
    logic start_l;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pwr_q <= 1'b1;
        end else begin
            pwr_q <= 1'b0;
        end
    end

    assign cmd_xst = wr_en && avs_address == OFS_CTRL
                     && avs_writedata[7:0] == CMD_XST;
    assign cmd_lst = wr_en && avs_address == OFS_CTRL
                     && avs_writedata[7:0] == CMD_LST;
    assign start_x = (pwr_q & cfg.cse) | (cmd_xst & ~cfg.dst);
    assign start_l = (pwr_q & cfg.lbe) | cmd_lst;

    // ****************************************
    // Oscillator watchdog
    // ****************************************
    // Never gated: the watchdog has no enable by design
    logic [2:0]  osc_s_q;
    logic [1:0]  peer_s_q;
    logic [15:0] win_q;
    logic [15:0] edges_q;
    logic        win_end;
    logic        wd_bad;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            osc_s_q  <= 3'b000;
            peer_s_q <= 2'b00;
        end else begin
            osc_s_q  <= {osc_s_q[1:0], osc_peer_clk};
            peer_s_q <= {peer_s_q[0], peer_wd_fault};
        end
    end

    assign win_end = win_q == 16'(WD_WIN_CYC - 1);
    assign wd_bad  = edges_q < 16'(WD_LO) || edges_q > 16'(WD_HI);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            win_q     <= 16'h0000;
            edges_q   <= 16'h0000;
            wd_last_q <= 16'h0000;
        end else if (win_end) begin
            win_q     <= 16'h0000;
            edges_q   <= 16'h0000;
            wd_last_q <= edges_q;
        end else begin
            win_q   <= win_q + 16'h0001;
            edges_q <= edges_q + {15'h0, osc_s_q[1] & ~osc_s_q[2]};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wd_fault_q <= 1'b0;
        end else if ((win_end & wd_bad) | peer_s_q[1]) begin
            wd_fault_q <= 1'b1;
        end
    end

    // ****************************************
    // Logic self-test
    // ****************************************
    logic [30:0]          lfsr_q;
    logic [30:0]          chain_out;
    logic [CHAIN_LEN-1:0] chain_q [NUM_CHAINS];
    logic [31:0]          lcnt_q;
    logic [30:0]          misr_d;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lrun_q  <= 1'b0;
            ldone_q <= 1'b0;
            lcnt_q  <= 32'h0000_0000;
        end else if (start_l & ~lrun_q) begin
            lrun_q  <= 1'b1;
            ldone_q <= 1'b0;
            lcnt_q  <= 32'h0000_0000;
        end else if (lrun_q) begin
            lcnt_q <= lcnt_q + 32'h0000_0001;
            if (lcnt_q == LST_CYCLES - 1) begin
                lrun_q  <= 1'b0;
                ldone_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lfsr_q <= LFSR_SEED;
        end else if (start_l & ~lrun_q) begin
            lfsr_q <= LFSR_SEED;
        end else if (lrun_q) begin
            lfsr_q <= {lfsr_q[29:0], lfsr_q[30] ^ lfsr_q[27]};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAINS; gi++) begin : g_chain
            assign chain_out[gi] = chain_q[gi][CHAIN_LEN-1];
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    chain_q[gi] <= '0;
                end else if (lrun_q) begin
                    chain_q[gi] <= {chain_q[gi][CHAIN_LEN-2:0],
                                    lfsr_q[gi]};
                end
            end
        end
    endgenerate

    assign misr_d = {misr_q[29:0], misr_q[30] ^ misr_q[27]} ^ chain_out;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            misr_q <= MISR_INIT;
        end else if (start_l & ~lrun_q) begin
            misr_q <= MISR_INIT;
        end else if (lrun_q) begin
            misr_q <= misr_d;
        end
    end

    // Verdict on the final signature, the same one software reads back
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lfail_q <= 1'b0;
        end else if (start_l & ~lrun_q) begin
            lfail_q <= 1'b0;
        end else if (lrun_q && lcnt_q == LST_CYCLES - 1) begin
            lfail_q <= misr_d != EXP_SIG;
        end
    end

    // ****************************************
    // Transducer self-test
    // ****************************************
    logic [31:0] xcnt_q;
    logic [2:0]  step_q;
    logic        seen_q;
    logic        bad_q;
    logic [11:0] diff;
    logic [11:0] adiff;
    logic        step_end;
    logic        last_step;

    // Expected angle advances one eighth of a turn per step
    assign diff      = angle_meas - {step_q, 9'h000};
    assign adiff     = diff[11] ? 12'h000 - diff : diff;
    assign step_end  = xs_q == XS_RUN && xcnt_q == STEP_CYCLES - 1;
    assign last_step = step_q == 3'(XST_STEPS - 1);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            xs_q   <= XS_IDLE;
            xcnt_q <= 32'h0000_0000;
            step_q <= 3'h0;
        end else begin
            case (xs_q)
                XS_IDLE, XS_DONE: begin
                    if (start_x) begin
                        xs_q   <= XS_RUN;
                        xcnt_q <= 32'h0000_0000;
                        step_q <= 3'h0;
                    end
                end
                XS_RUN: begin
                    xcnt_q <= xcnt_q + 32'h0000_0001;
                    if (step_end) begin
                        xcnt_q <= 32'h0000_0000;
                        step_q <= step_q + 3'h1;
                        if (last_step) begin
                            xs_q <= XS_DONE;
                        end
                    end
                end
                default: xs_q <= XS_IDLE;
            endcase
        end
    end

    // Stimulus: direction flips every step, element walks round
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stim <= '0;
        end else begin
            stim.test_cfg <= xs_q == XS_RUN;
            stim.cur_dir  <= step_q[0];
            stim.elem     <= step_q;
        end
    end

    // Each step must show at least one in-tolerance angle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seen_q <= 1'b0;
            bad_q  <= 1'b0;
        end else if (xs_q != XS_RUN) begin
            seen_q <= 1'b0;
            bad_q  <= 1'b0;
        end else if (step_end) begin
            seen_q <= 1'b0;
            bad_q  <= bad_q | ~seen_q;
        end else if (angle_valid && adiff <= ANGLE_TOL) begin
            seen_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sdn_q <= 1'b0;
        end else if (xs_q != XS_RUN && start_x) begin
            sdn_q <= 1'b0;
        end else if (step_end & last_step) begin
            sdn_q <= 1'b1;
        end
    end

    // Host clears with write-1; a failure in the same cycle wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stf_q <= 1'b0;
        end else if (ev[EV_XF]) begin
            stf_q <= 1'b1;
        end else if (wr_en && avs_address == OFS_ERR
                     && avs_writedata[0]) begin
            stf_q <= 1'b0;
        end
    end

    assign ev[EV_XDN] = step_end & last_step;
    assign ev[EV_LDN] = lrun_q && lcnt_q == LST_CYCLES - 1;
    assign ev[EV_XF]  = step_end & last_step & (bad_q | ~seen_q);
    assign ev[EV_WD]  = ((win_end & wd_bad) | peer_s_q[1]) & ~wd_fault_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    cmd_starts_xst_a: assert property (
        cmd_xst && !cfg.dst && xs_q != XS_RUN |=> xs_q == XS_RUN)
        else $error("special command did not start test");
    dst_blocks_a: assert property (
        xs_q != XS_RUN && cmd_xst && cfg.dst && !pwr_q |=> xs_q != XS_RUN)
        else $error("disabled command started test");
    done_ends_run_a: assert property (
        xs_q == XS_RUN ##1 xs_q == XS_DONE |-> sdn_q ##1 !stim.test_cfg)
        else $error("done and running disagree");
    test_cfg_a: assert property (
        xs_q == XS_RUN |=> stim.test_cfg)
        else $error("test configuration not applied");
    fail_sets_stf_a: assert property (
        ev[EV_XF] |=> stf_q && sdn_q)
        else $error("failure flag not set");
    lst_concurrent_a: assert property (
        start_l && !lrun_q && xs_q == XS_RUN |=> lrun_q && xs_q == XS_RUN)
        else $error("tests blocked each other");
    lst_sig_a: assert property (
        ev[EV_LDN] |=> lfail_q == (misr_q != EXP_SIG) && ldone_q)
        else $error("signature verdict wrong");
    wd_flag_a: assert property (
        win_end && wd_bad |=> wd_fault_q && wd_last_q == $past(edges_q))
        else $error("watchdog fault not flagged");
    step_adv_a: assert property (
        step_end && !last_step |=> step_q == $past(step_q) + 3'h1
        && xs_q == XS_RUN)
        else $error("step did not advance");
    istat_keep_a: assert property (
        !(rd_done && avs_address == OFS_ISTAT)
        |=> (istat_q & $past(istat_q)) == $past(istat_q))
        else $error("event bit lost before read");

    xst_pass_c: cover property (ev[EV_XDN] && !ev[EV_XF]);
    xst_fail_c: cover property (ev[EV_XF]);
    both_run_c: cover property (lrun_q && xs_q == XS_RUN);
    wd_fault_c: cover property (ev[EV_WD]);
endmodule
`default_nettype wire
